// ---- common/slpb_params.svh ----
`ifndef SLPB_PARAMS_SVH
`define SLPB_PARAMS_SVH

// request level must be seen this many input clock cycles
`define SLPB_REQ_STABLE      3'h4
// generator seeds, one per lane, non-zero; the checker starts from zero
`define SLPB_SEED_LANE0      7'h01
`define SLPB_SEED_LANE1      7'h5A
// consecutive matching symbols that declare the test pattern present
`define SLPB_DETECT_RUN      7'h20
`define SLPB_DETECT_LIMIT    128
// misses per 128-symbol window that drop the checker out of test mode
`define SLPB_WIN_LAST        7'h7F
`define SLPB_EXIT_MISSES     8'h20
// symbols per lane before the pass flag rises
`define SLPB_PASS_SYMBOLS    44000000
`define SLPB_PASS_CNT_W      26
`define SLPB_ERR_MAX         7'h7F
// status placement on the parallel output in test mode
`define SLPB_PASS_BIT0       0
`define SLPB_ERR_LSB0        1
`define SLPB_PASS_BIT1       16
`define SLPB_ERR_LSB1        17
`define SLPB_FIFO_DEPTH      16
`define SLPB_WORD_LAST       4'hF

`endif

// ---- common/slpb_pkg.sv ----
package slpb_pkg;

   typedef enum logic {
      SLPB_MODE_NORMAL,
      SLPB_MODE_TEST
   } slpb_mode_e;

   typedef logic [6:0] slpb_prbs_t;

endpackage : slpb_pkg

// ---- common/slpb_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface slpb_stream_if #(
   parameter int WIDTH = 32
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : slpb_stream_if

`default_nettype wire

// ---- rtl/slpb_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module slpb_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic     sys_clk_i,
   input wire logic     rst_i,
   // streams
   slpb_stream_if.snk   in_s,
   slpb_stream_if.src   out_s
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("slpb_fifo: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             ready_reg, ready_next, valid_reg, valid_next;
   logic [WIDTH-1:0] data_reg, data_next;
   logic             push, pop;

   always_comb begin
      push = in_s.valid && ready_reg;
      pop  = valid_reg && out_s.ready;
      wr_next  = push ? wr_reg + 1'b1 : wr_reg;
      rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      ready_next = cnt_next != (AW+1)'(DEPTH);
      valid_next = cnt_next != '0;
      // head is read ahead so the output comes from a register
      if (push && wr_reg == rd_next) begin
         data_next = in_s.data;
      end else begin
         data_next = mem[rd_next];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_reg] <= in_s.data;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         cnt_reg   <= '0;
         ready_reg <= 1'b0;
         valid_reg <= 1'b0;
         data_reg  <= '0;
      end else begin
         wr_reg    <= wr_next;
         rd_reg    <= rd_next;
         cnt_reg   <= cnt_next;
         ready_reg <= ready_next;
         valid_reg <= valid_next;
         data_reg  <= data_next;
      end
   end

   assign in_s.ready  = ready_reg;
   assign out_s.valid = valid_reg;
   assign out_s.data  = data_reg;

endmodule : slpb_fifo

`default_nettype wire

// ---- rtl/slpb_serdes_bist.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "slpb_params.svh"

module slpb_serdes_bist #(
   parameter int PASS_SYMBOLS = `SLPB_PASS_SYMBOLS,
   parameter int FIFO_DEPTH   = `SLPB_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // host side of the serializer
   input  wire logic        self_test_request_i,
   input  wire logic [31:0] parallel_data_in_i,
   input  wire logic        parallel_data_in_valid_i,
   output logic             parallel_data_in_ready_o,
   // serial lanes out
   output logic [1:0]       tx_serial_o,
   output logic             tx_test_active_o,
   // serial lanes in
   input  wire logic [1:0]  rx_serial_i,
   input  wire logic [1:0]  rx_lane_lock_i,
   // deserializer parallel side
   output logic [31:0]      parallel_data_out_o,
   output logic             lock_o,
   output logic             rx_test_active_o
);
   localparam int CW = `SLPB_PASS_CNT_W;
   localparam logic [CW-1:0] PASS_LAST = CW'(PASS_SYMBOLS);

   initial begin
      if (PASS_SYMBOLS < 1 || PASS_SYMBOLS >= (1 << CW)) begin
         $error("slpb_serdes_bist: PASS_SYMBOLS out of range");
      end
      if (`SLPB_DETECT_RUN > `SLPB_DETECT_LIMIT) begin
         $error("slpb_serdes_bist: detect run exceeds 128 symbols");
      end
   end

   // pins cross into the clock domain through two flops
   logic [4:0] meta_reg, sync_reg;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= {self_test_request_i, rx_lane_lock_i, rx_serial_i};
         sync_reg <= meta_reg;
      end
   end

   logic       req_s, lock_all;
   logic [1:0] rx_bit;
   assign req_s    = sync_reg[4];
   assign lock_all = &sync_reg[3:2];
   assign rx_bit   = sync_reg[1:0];

   // ---------------- serializer side ----------------
   slpb_stream_if #(.WIDTH(32)) in_if ();
   slpb_stream_if #(.WIDTH(32)) out_if ();

   assign in_if.valid = parallel_data_in_valid_i;
   assign in_if.data  = parallel_data_in_i;
   assign parallel_data_in_ready_o = in_if.ready;

   slpb_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .in_s      (in_if),
      .out_s     (out_if)
   );

   slpb_pkg::slpb_mode_e tx_mode_reg, tx_mode_next;
   logic                 req_last_reg, req_last_next;
   logic [2:0]           stab_reg, stab_next;
   logic [3:0]           tx_cnt_reg, tx_cnt_next;
   logic                 tx_test;
   logic [31:0]          load_word;

   always_comb begin
      req_last_next = req_s;
      if (req_s != req_last_reg) begin
         stab_next = 3'h1;
      end else if (stab_reg == `SLPB_REQ_STABLE) begin
         stab_next = stab_reg;
      end else begin
         stab_next = stab_reg + 3'h1;
      end
      tx_mode_next = tx_mode_reg;
      // a shorter pulse never reaches the count, so mode stays put
      if (stab_next == `SLPB_REQ_STABLE) begin
         tx_mode_next = req_s ? slpb_pkg::SLPB_MODE_TEST
                              : slpb_pkg::SLPB_MODE_NORMAL;
      end
      tx_cnt_next = tx_cnt_reg + 4'h1;
   end

   assign tx_test = tx_mode_reg == slpb_pkg::SLPB_MODE_TEST;
   // test mode drains and discards the input words
   assign out_if.ready = tx_test || tx_cnt_reg == 4'h0;
   assign load_word = (out_if.valid && !tx_test && tx_cnt_reg == 4'h0)
                      ? out_if.data : 32'h0000_0000;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tx_mode_reg  <= slpb_pkg::SLPB_MODE_NORMAL;
         req_last_reg <= 1'b0;
         stab_reg     <= 3'h0;
         tx_cnt_reg   <= 4'h0;
      end else begin
         tx_mode_reg  <= tx_mode_next;
         req_last_reg <= req_last_next;
         stab_reg     <= stab_next;
         tx_cnt_reg   <= tx_cnt_next;
      end
   end

   // ---------------- deserializer side ----------------
   slpb_pkg::slpb_mode_e rx_mode_reg, rx_mode_next;
   logic [6:0]           win_reg, win_next;
   logic [3:0]           rx_cnt_reg, rx_cnt_next;
   logic [31:0]          out_reg, out_next;
   logic                 lock_reg, counting;
   logic [1:0]           detected, exit_req, pass_flag;
   logic [6:0]           err_cnt [2];
   logic [15:0]          deser_next [2];

   assign counting = rx_mode_reg == slpb_pkg::SLPB_MODE_TEST
                     && lock_all;

   genvar l;
   generate
      for (l = 0; l < 2; l++) begin : g_lane
         localparam slpb_pkg::slpb_prbs_t SEED =
            (l == 0) ? `SLPB_SEED_LANE0 : `SLPB_SEED_LANE1;
         slpb_pkg::slpb_prbs_t lfsr_reg, lfsr_next, chk_reg, chk_next;
         logic [15:0]     shift_reg, shift_next, deser_reg;
         logic            tx_reg, tx_next, fb, mism;
         logic [6:0]      run_reg, run_next, err_reg, err_next;
         logic [7:0]      miss_reg, miss_next;
         logic [CW-1:0]   pcnt_reg, pcnt_next;
         logic            pass_reg, pass_next;

         always_comb begin
            fb = lfsr_reg[6] ^ lfsr_reg[5];
            lfsr_next = tx_test ? {lfsr_reg[5:0], fb} : SEED;
            shift_next = (tx_cnt_reg == 4'h0) ? load_word[16*l +: 16]
                                              : {1'b0, shift_reg[15:1]};
            tx_next = tx_test ? fb : shift_next[0];

            // self-synchronising checker, one per lane
            mism = rx_bit[l] != (chk_reg[6] ^ chk_reg[5]);
            chk_next = {chk_reg[5:0], rx_bit[l]};
            deser_next[l] = {rx_bit[l], deser_reg[15:1]};
            // an idle all-zero stream also fits the recurrence
            if (mism || chk_reg == 7'h00) begin
               run_next = 7'h00;
            end else if (run_reg == `SLPB_DETECT_RUN) begin
               run_next = run_reg;
            end else begin
               run_next = run_reg + 7'h01;
            end
            if (rx_mode_reg == slpb_pkg::SLPB_MODE_NORMAL
                || win_reg == 7'h00) begin
               miss_next = {7'h00, mism};
            end else begin
               miss_next = miss_reg + {7'h00, mism};
            end

            err_next  = err_reg;
            pcnt_next = pcnt_reg;
            pass_next = pass_reg;
            if (rx_mode_reg == slpb_pkg::SLPB_MODE_NORMAL) begin
               err_next  = 7'h00;
               pcnt_next = '0;
               pass_next = 1'b0;
            end else if (counting) begin
               if (mism && err_reg != `SLPB_ERR_MAX) begin
                  err_next = err_reg + 7'h01;
               end
               if (pcnt_reg != PASS_LAST) begin
                  pcnt_next = pcnt_reg + CW'(1);
               end
               // sticky once set
               pass_next = pass_reg || pcnt_next == PASS_LAST;
            end
         end

         assign detected[l] = run_reg == `SLPB_DETECT_RUN;
         assign exit_req[l] = win_reg == `SLPB_WIN_LAST
                              && miss_reg >= `SLPB_EXIT_MISSES;
         assign pass_flag[l] = pass_reg;
         assign err_cnt[l]   = err_reg;
         assign tx_serial_o[l] = tx_reg;

         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               lfsr_reg  <= SEED;
               shift_reg <= 16'h0000;
               tx_reg    <= 1'b0;
               chk_reg   <= 7'h00;
               deser_reg <= 16'h0000;
               run_reg   <= 7'h00;
               miss_reg  <= 8'h00;
               err_reg   <= 7'h00;
               pcnt_reg  <= '0;
               pass_reg  <= 1'b0;
            end else begin
               lfsr_reg  <= lfsr_next;
               shift_reg <= shift_next;
               tx_reg    <= tx_next;
               chk_reg   <= chk_next;
               deser_reg <= deser_next[l];
               run_reg   <= run_next;
               miss_reg  <= miss_next;
               err_reg   <= err_next;
               pcnt_reg  <= pcnt_next;
               pass_reg  <= pass_next;
            end
         end
      end
   endgenerate

   always_comb begin
      win_next    = win_reg + 7'h01;
      rx_cnt_next = lock_all ? rx_cnt_reg + 4'h1 : 4'h0;
      rx_mode_next = rx_mode_reg;
      case (rx_mode_reg)
         slpb_pkg::SLPB_MODE_NORMAL: begin
            // no control pin: the pattern itself switches the mode
            if (lock_all && &detected) begin
               rx_mode_next = slpb_pkg::SLPB_MODE_TEST;
            end
         end
         slpb_pkg::SLPB_MODE_TEST: begin
            // random payload misses about half the bits
            if (!lock_all || |exit_req) begin
               rx_mode_next = slpb_pkg::SLPB_MODE_NORMAL;
            end
         end
         default: rx_mode_next = slpb_pkg::SLPB_MODE_NORMAL;
      endcase

      out_next = out_reg;
      if (rx_mode_reg == slpb_pkg::SLPB_MODE_TEST) begin
         out_next = 32'h0000_0000;
         out_next[`SLPB_PASS_BIT0] = pass_flag[0];
         out_next[`SLPB_PASS_BIT1] = pass_flag[1];
         out_next[`SLPB_ERR_LSB0 +: 7] = err_cnt[0];
         out_next[`SLPB_ERR_LSB1 +: 7] = err_cnt[1];
      end else if (lock_all && rx_cnt_reg == `SLPB_WORD_LAST) begin
         out_next = {deser_next[1], deser_next[0]};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rx_mode_reg <= slpb_pkg::SLPB_MODE_NORMAL;
         win_reg     <= 7'h00;
         rx_cnt_reg  <= 4'h0;
         out_reg     <= 32'h0000_0000;
         lock_reg    <= 1'b0;
      end else begin
         rx_mode_reg <= rx_mode_next;
         win_reg     <= win_next;
         rx_cnt_reg  <= rx_cnt_next;
         out_reg     <= out_next;
         lock_reg    <= lock_all;
      end
   end

   assign parallel_data_out_o = out_reg;
   assign lock_o              = lock_reg;
   assign rx_test_active_o    = rx_mode_reg == slpb_pkg::SLPB_MODE_TEST;
   assign tx_test_active_o    = tx_test;

endmodule : slpb_serdes_bist

`default_nettype wire

// ---- testbench/slpb_serdes_bist_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module slpb_chk #(
   parameter int PASS_SYMBOLS = 200
) (
   // clock and reset
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   // host side
   input wire logic        self_test_request_i,
   input wire logic [31:0] parallel_data_in_i,
   input wire logic        parallel_data_in_valid_i,
   input wire logic        parallel_data_in_ready_o,
   // serial lanes
   input wire logic [1:0]  tx_serial_o,
   input wire logic        tx_test_active_o,
   input wire logic [1:0]  rx_serial_i,
   input wire logic [1:0]  rx_lane_lock_i,
   // parallel side
   input wire logic [31:0] parallel_data_out_o,
   input wire logic        lock_o,
   input wire logic        rx_test_active_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // cycles spent in test on each side, tx one saturates
   logic [3:0] tx_cnt_reg;
   int         rx_cnt_reg;
   always_ff @(posedge sys_clk_i) begin
      tx_cnt_reg <= (rst_i || !tx_test_active_o) ? 4'h0 :
                    tx_cnt_reg + {3'h0, tx_cnt_reg != 4'hF};
      rx_cnt_reg <= (rst_i || !rx_test_active_o) ? 32'h0 : rx_cnt_reg + 32'h1;
   end

   property p_enter;
      $rose(tx_test_active_o) |-> $past(self_test_request_i, 3) &&
         $past(self_test_request_i, 4) && $past(self_test_request_i, 5) &&
         $past(self_test_request_i, 6);
   endproperty
   a_enter: assert property (p_enter)
      else $error("test mode entered after a short request");
   property p_leave;
      $fell(tx_test_active_o) |-> !$past(self_test_request_i, 3) &&
         !$past(self_test_request_i, 4) && !$past(self_test_request_i, 5) &&
         !$past(self_test_request_i, 6);
   endproperty
   a_leave: assert property (p_leave)
      else $error("test mode left after a short release");
   // recurrence of x^7+x^6+1 holds whatever the seed
   property p_prbs;
      tx_cnt_reg >= 4'hA |->
         tx_serial_o == ($past(tx_serial_o, 6) ^ $past(tx_serial_o, 7));
   endproperty
   a_prbs: assert property (p_prbs)
      else $error("lane stream is not the 7-stage sequence");
   property p_detect;
      $rose(tx_test_active_o) && rx_lane_lock_i == 2'h3
         |-> ##[1:136] rx_test_active_o;
   endproperty
   a_detect: assert property (p_detect)
      else $error("receiver missed the test pattern");
   property p_lock;
      lock_o |-> $past(rx_lane_lock_i, 3) == 2'h3;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock high while a lane is unlocked");
   property p_zero;
      rx_test_active_o[*3] |-> parallel_data_out_o[31:24] == 8'h00 &&
         parallel_data_out_o[15:8] == 8'h00;
   endproperty
   a_zero: assert property (p_zero)
      else $error("unused status bits not zero");
   property p_sticky;
      rx_test_active_o[*3] |->
         (!$past(parallel_data_out_o[0]) || parallel_data_out_o[0]) &&
         (!$past(parallel_data_out_o[16]) || parallel_data_out_o[16]);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("pass flag fell during test");
   property p_err;
      rx_test_active_o[*3] |->
         parallel_data_out_o[7:1] >= $past(parallel_data_out_o[7:1]) &&
         parallel_data_out_o[7:1] <= $past(parallel_data_out_o[7:1]) + 8'h01
         && parallel_data_out_o[23:17] >= $past(parallel_data_out_o[23:17])
         && parallel_data_out_o[23:17]
            <= $past(parallel_data_out_o[23:17]) + 8'h01;
   endproperty
   a_err: assert property (p_err)
      else $error("error count wrapped or jumped");
   property p_pass;
      $rose(parallel_data_out_o[0]) && rx_test_active_o
         |-> rx_cnt_reg >= PASS_SYMBOLS - 1;
   endproperty
   a_pass: assert property (p_pass)
      else $error("pass flag rose too early");
endmodule : slpb_chk

bind slpb_serdes_bist slpb_chk #(.PASS_SYMBOLS(PASS_SYMBOLS)) u_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .self_test_request_i(self_test_request_i),
   .parallel_data_in_i(parallel_data_in_i),
   .parallel_data_in_valid_i(parallel_data_in_valid_i),
   .parallel_data_in_ready_o(parallel_data_in_ready_o),
   .tx_serial_o(tx_serial_o), .tx_test_active_o(tx_test_active_o),
   .rx_serial_i(rx_serial_i), .rx_lane_lock_i(rx_lane_lock_i),
   .parallel_data_out_o(parallel_data_out_o), .lock_o(lock_o),
   .rx_test_active_o(rx_test_active_o));

`default_nettype wire

// ---- testbench/slpb_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none

module slpb_far_end (
   // clock
   input  wire logic       sys_clk_i,
   // lanes and control
   input  wire logic [1:0] tx_serial_i,
   input  wire logic [1:0] flip_i,
   input  wire logic [1:0] lock_req_i,
   output logic      [1:0] rx_serial_o,
   output logic      [1:0] lane_lock_o
);
   // one cycle of wire delay, bit errors per lane on command
   always_ff @(posedge sys_clk_i) begin
      rx_serial_o <= tx_serial_i ^ flip_i;
      lane_lock_o <= lock_req_i;
   end
endmodule : slpb_far_end

`default_nettype wire

// ---- testbench/tb_slpb_serdes_bist.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_slpb_serdes_bist;
   localparam int PASS = 200;
   typedef struct packed { logic [3:0] len; logic act; } slpb_row_s;
   logic        sys_clk_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic        req       = 1'b0;
   logic        din_vld   = 1'b0;
   logic [31:0] din       = 32'h0;
   logic [1:0]  flip      = 2'h0;
   logic [1:0]  lock_req  = 2'h0;
   logic        ready, tx_act, rx_act, lock;
   logic [1:0]  tx_ser, rx_ser, rx_lock;
   logic [31:0] dout;
   logic        saw;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          cyc        = 0;
   int          n;
   slpb_row_s   rows [4] = '{'{4'h1, 1'b0}, '{4'h3, 1'b0},
                             '{4'h4, 1'b1}, '{4'h6, 1'b1}};

   slpb_serdes_bist #(.PASS_SYMBOLS(PASS)) DUT (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .self_test_request_i(req),
      .parallel_data_in_i(din), .parallel_data_in_valid_i(din_vld),
      .parallel_data_in_ready_o(ready), .tx_serial_o(tx_ser),
      .tx_test_active_o(tx_act), .rx_serial_i(rx_ser),
      .rx_lane_lock_i(rx_lock), .parallel_data_out_o(dout),
      .lock_o(lock), .rx_test_active_o(rx_act));
   slpb_far_end u_far (
      .sys_clk_i(sys_clk_i), .tx_serial_i(tx_ser), .flip_i(flip),
      .lock_req_i(lock_req), .rx_serial_o(rx_ser), .lane_lock_o(rx_lock));

   always #25 sys_clk_i = ~sys_clk_i;

   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask : tick

   // hang guard, the whole run needs about 2500 cycles
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   initial begin
      tick(6);
      rst_i <= 1'b0;
      @(negedge sys_clk_i);
      check("idle flags", {28'h0, tx_act, rx_act, lock, ready}, 32'h0);
      check("idle out", dout, 32'h0);
      tick(3);
      // lanes unlocked here so short test bursts stay local to the sender
      foreach (rows[i]) begin
         saw = 1'b0;
         req <= 1'b1;
         tick(rows[i].len);
         req <= 1'b0;
         repeat (14) begin
            @(posedge sys_clk_i);
            saw |= tx_act;
         end
         check("pulse", saw, rows[i].act);
         check("left", tx_act, 1'b0);
      end
      lock_req <= 2'h3;
      tick(8);
      @(negedge sys_clk_i);
      check("lock", lock, 1'b1);
      tick(1);
      din     <= 32'hA5A5_0F0F;
      din_vld <= 1'b1;
      n = 0;
      while (ready !== 1'b0 && n < 40) begin
         tick(1);
         n++;
      end
      check("fill", n >= 16 && n <= 20, 1'b1);
      req <= 1'b1;
      n = 0;
      while (tx_act !== 1'b1 && n < 12) begin
         tick(1);
         n++;
      end
      n = 0;
      while (rx_act !== 1'b1 && n < 132) begin
         tick(1);
         n++;
      end
      check("detect", rx_act, 1'b1);
      check("drain", ready, 1'b1);
      din_vld <= 1'b0;
      tick(PASS - 20);
      @(negedge sys_clk_i);
      check("early", {dout[16], dout[0]}, 2'h0);
      tick(40);
      @(negedge sys_clk_i);
      check("status", dout, 32'h0001_0001);
      tick(1);
      flip <= 2'h1;
      tick(1);
      flip <= 2'h0;
      tick(20);
      @(negedge sys_clk_i);
      check("lane1 clean", dout[31:16], 32'h1);
      check("lane0 hit", dout[7:1] >= 7'h01 && dout[7:1] <= 7'h03, 1'b1);
      // spaced errors stay below the window limit that ends test
      repeat (130) begin
         tick(1);
         flip <= 2'h2;
         tick(1);
         flip <= 2'h0;
         tick(14);
      end
      tick(20);
      @(negedge sys_clk_i);
      check("saturate", dout[23:16], 32'hFF);
      check("lane0 pass", {rx_act, dout[0]}, 2'h3);
      tick(1);
      lock_req <= 2'h1;
      tick(5);
      @(negedge sys_clk_i);
      check("unlock", lock, 1'b0);
      tick(1);
      req <= 1'b0;
      tick(10);
      check("exit", tx_act, 1'b0);
      wrap_up();
   end
endmodule : tb_slpb_serdes_bist

`default_nettype wire
